// File: include/scs_map.svh
// Address map, field positions, codes and timing counts of the sequencer
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

// Register byte offsets
`define SCS_CTRL_OFF      12'h000
`define SCS_STATUS_OFF    12'h004
`define SCS_RESULT_OFF    12'h008

// Control fields
`define SCS_CTRL_PIN_EN   0
`define SCS_CTRL_SW_START 1
`define SCS_CTRL_RST_VAL  32'h0000_0001

// Status fields
`define SCS_ST_BUSY       0
`define SCS_ST_CAL        1
`define SCS_ST_STALE      2
`define SCS_ST_CODING     3
`define SCS_ST_MODE_LO    4
`define SCS_ST_MODE_HI    6

// Result codes
`define SCS_RES_W         16
`define SCS_CODE_ZERO     16'h0000
`define SCS_CODE_TOP      16'hffff
`define SCS_CODE_MID      16'h8000
`define SCS_LSB_MASK      16'h0001

// Timing: clock rate and documented sample rates
`define SCS_CLK_KHZ       100000
`define SCS_FAST_KSPS     2000
`define SCS_FREE_KSPS     1500
`define SCS_FAST_PER_CYC  ((`SCS_CLK_KHZ + `SCS_FAST_KSPS - 1) / `SCS_FAST_KSPS)
`define SCS_FREE_PER_CYC  ((`SCS_CLK_KHZ + `SCS_FREE_KSPS - 1) / `SCS_FREE_KSPS)
`define SCS_STALE_US      1000
`define SCS_STALE_CYC     (`SCS_STALE_US * (`SCS_CLK_KHZ / 1000))
`define SCS_CAL_CYC       8'd16
`define SCS_GAP_W         20

`endif

// File: include/scs_pkg.sv
// Types shared by the conversion sequencer
package scs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CAL  = 3'b010,
    ST_CONV = 3'b100
  } scs_state_t;

  typedef enum logic [2:0] {
    MD_WIDE = 3'b001,
    MD_FAST = 3'b010,
    MD_FREE = 3'b100
  } scs_mode_t;

endpackage

// File: logic/scs_sar_conversion_sequencer.sv
// Successive-approximation conversion sequencer with APB register access
// Functional notes
// - Start edge after acquisition begins conversion
// - Resolve 16 bits, MSB first
// - Form code, then drop busy
// - Result belongs to own start's sample
// - Decode speed and accuracy pins to modes
// - Fast modes accept starts up to 2 MSPS
// - Unrestricted mode 1.5 MSPS, no gap limit
// - Coding pin picks binary or twos complement
// - Midscale codes; twos complement flips MSB
// - Over-range saturates to top code
// - Under-range saturates to bottom code
// - Reset input high aborts conversion
// - Reset falling edge runs calibration busy pulse
// - Power-down finishes conversion, then ignores starts
//
// Decided for this implementation: the APB slave port and the address map.
`include "scs_map.svh"

module scs_sar_conversion_sequencer
  import scs_pkg::*;
#(
  parameter int unsigned STALE_CYC = `SCS_STALE_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device control pins
  input  wire logic        convert_start_n,
  input  wire logic        adc_reset,
  input  wire logic        power_down_in,
  input  wire logic        speed_sel,
  input  wire logic        accuracy_sel,
  input  wire logic        output_coding_sel,
  output logic             busy,
  output logic [15:0]      result_code,
  output logic             stale_result,
  // Converter array
  input  wire logic        comp_in,
  input  wire logic        over_range,
  input  wire logic        under_range,
  output logic [15:0]      dac_trial,
  output logic             pos_array_ground_switch,
  output logic             neg_array_ground_switch
);

  // Gap limits in cycles; gap restarts at one so a full period is accepted
  localparam logic [`SCS_GAP_W-1:0] STALE_LIM = `SCS_GAP_W'(STALE_CYC);
  localparam logic [`SCS_GAP_W-1:0] FAST_PER  = `SCS_GAP_W'(`SCS_FAST_PER_CYC);
  localparam logic [`SCS_GAP_W-1:0] FREE_PER  = `SCS_GAP_W'(`SCS_FREE_PER_CYC);
  localparam logic [`SCS_GAP_W-1:0] GAP_ONE   = `SCS_GAP_W'(1);

  scs_state_t                state_ff, nxt_state;
  logic [`SCS_RES_W-1:0]     trial_ff, nxt_trial;
  logic [`SCS_RES_W-1:0]     mask_ff, nxt_mask;
  logic [`SCS_RES_W-1:0]     result_ff, nxt_result;
  logic [`SCS_GAP_W-1:0]     gap_ff, nxt_gap;
  logic [7:0]                cal_ff, nxt_cal;
  logic                      busy_ff, nxt_busy;
  logic                      stale_ff, nxt_stale;
  logic                      cnv_q_ff, rst_q_ff;
  logic                      acq_ff, nxt_acq;
  logic                      pin_en_ff, nxt_pin_en;
  logic [31:0]               rdata_ff, nxt_rdata;
  scs_mode_t                 mode;
  logic                      fast_mode, start_edge, sw_start, acq_done;
  logic                      req, done_w, hit;
  logic [`SCS_RES_W-1:0]     kept, code_w;

  // Mode pin decode; speed low with accuracy high falls back to unrestricted
  always_comb begin
    if (speed_sel && accuracy_sel) begin
      mode = MD_WIDE;
    end else if (speed_sel) begin
      mode = MD_FAST;
    end else begin
      mode = MD_FREE;
    end
  end
  assign fast_mode = (mode != MD_FREE);

  // APB decode; zero-wait access with read data latched in setup
  assign hit      = (paddr == `SCS_CTRL_OFF) || (paddr == `SCS_STATUS_OFF)
                 || (paddr == `SCS_RESULT_OFF);
  assign pready   = psel & penable;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = rdata_ff;
  assign sw_start = psel & penable & pwrite & (paddr == `SCS_CTRL_OFF)
                  & pwdata[`SCS_CTRL_SW_START];

  // Start qualification: edge, acquisition time, power-down, idle
  assign start_edge = cnv_q_ff & ~convert_start_n;
  assign acq_done   = gap_ff >= (fast_mode ? FAST_PER : FREE_PER);
  assign req = ((start_edge & pin_en_ff) | sw_start) & acq_done
             & ~power_down_in & ~adc_reset
             & (state_ff == ST_IDLE) & ~rst_q_ff;

  // Bit decision and output code formation
  assign kept   = comp_in ? trial_ff : (trial_ff & ~mask_ff);
  assign done_w = (state_ff == ST_CONV) & mask_ff[0] & ~adc_reset;
  always_comb begin
    if (over_range) begin
      code_w = `SCS_CODE_TOP;
    end else if (under_range) begin
      code_w = `SCS_CODE_ZERO;
    end else begin
      code_w = kept;
    end
    if (!output_coding_sel) begin
      code_w[`SCS_RES_W-1] = ~code_w[`SCS_RES_W-1];
    end
  end

  // Next state of the sequencer, counters and registers
  always_comb begin
    nxt_state  = state_ff;
    nxt_trial  = trial_ff;
    nxt_mask   = mask_ff;
    nxt_result = result_ff;
    nxt_busy   = busy_ff;
    nxt_stale  = stale_ff;
    nxt_cal    = cal_ff;
    nxt_acq    = acq_ff;
    nxt_pin_en = pin_en_ff;
    nxt_rdata  = rdata_ff;
    nxt_gap    = (gap_ff >= STALE_LIM) ? gap_ff : gap_ff + 1'b1;
    case (state_ff)
      ST_IDLE: begin
        if (req) begin
          nxt_state = ST_CONV;
          nxt_busy  = 1'b1;
          nxt_acq   = 1'b0;
          nxt_trial = `SCS_CODE_MID;
          nxt_mask  = `SCS_CODE_MID;
          nxt_stale = fast_mode & (gap_ff >= STALE_LIM);
          nxt_gap   = GAP_ONE;
        end
      end
      ST_CONV: begin
        nxt_mask  = mask_ff >> 1;
        nxt_trial = kept | (mask_ff >> 1);
        if (mask_ff[0]) begin
          nxt_state  = ST_IDLE;
          nxt_result = code_w;
          nxt_busy   = 1'b0;
          nxt_acq    = 1'b1;
        end
      end
      ST_CAL: begin
        nxt_cal = cal_ff - 1'b1;
        if (cal_ff == 8'd1) begin
          nxt_state = ST_IDLE;
          nxt_busy  = 1'b0;
          nxt_acq   = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_busy  = 1'b0;
      end
    endcase
    // Reset pin aborts conversion or calibration; its release starts calibration
    if (adc_reset) begin
      nxt_state = ST_IDLE;
      nxt_busy  = 1'b0;
      nxt_result = result_ff;
      nxt_acq   = 1'b1;
      nxt_gap   = STALE_LIM;
    end else if (rst_q_ff) begin
      nxt_state = ST_CAL;
      nxt_busy  = 1'b1;
      nxt_cal   = `SCS_CAL_CYC;
      nxt_acq   = 1'b0;
    end
    // Register writes and read data capture
    if (psel && penable && pwrite && paddr == `SCS_CTRL_OFF) begin
      nxt_pin_en = pwdata[`SCS_CTRL_PIN_EN];
    end
    if (psel && !penable) begin
      nxt_rdata = 32'h0000_0000;
      case (paddr)
        `SCS_CTRL_OFF:   nxt_rdata[`SCS_CTRL_PIN_EN] = pin_en_ff;
        `SCS_STATUS_OFF: begin
          nxt_rdata[`SCS_ST_BUSY]   = busy_ff;
          nxt_rdata[`SCS_ST_CAL]    = (state_ff == ST_CAL);
          nxt_rdata[`SCS_ST_STALE]  = stale_ff;
          nxt_rdata[`SCS_ST_CODING] = output_coding_sel;
          nxt_rdata[`SCS_ST_MODE_HI:`SCS_ST_MODE_LO] = mode;
        end
        `SCS_RESULT_OFF: nxt_rdata[`SCS_RES_W-1:0] = result_ff;
        default:         nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff  <= ST_IDLE;
      trial_ff  <= `SCS_CODE_ZERO;
      mask_ff   <= `SCS_CODE_ZERO;
      result_ff <= `SCS_CODE_ZERO;
      busy_ff   <= 1'b0;
      stale_ff  <= 1'b0;
      cal_ff    <= 8'd0;
      acq_ff    <= 1'b1;
      pin_en_ff <= 1'(`SCS_CTRL_RST_VAL);
      rdata_ff  <= 32'h0000_0000;
      gap_ff    <= STALE_LIM;
      cnv_q_ff  <= 1'b1;
      rst_q_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      trial_ff  <= nxt_trial;
      mask_ff   <= nxt_mask;
      result_ff <= nxt_result;
      busy_ff   <= nxt_busy;
      stale_ff  <= nxt_stale;
      cal_ff    <= nxt_cal;
      acq_ff    <= nxt_acq;
      pin_en_ff <= nxt_pin_en;
      rdata_ff  <= nxt_rdata;
      gap_ff    <= nxt_gap;
      cnv_q_ff  <= convert_start_n;
      rst_q_ff  <= adc_reset;
    end
  end

  // Outputs
  assign busy                    = busy_ff;
  assign result_code             = result_ff;
  assign stale_result            = stale_ff;
  assign dac_trial               = trial_ff;
  assign pos_array_ground_switch = acq_ff;
  assign neg_array_ground_switch = acq_ff;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_conv_run;
    busy_ff [*8] ##1 busy_ff [*8];
  endsequence
  sequence s_conv_end;
    !busy_ff && (state_ff == ST_IDLE);
  endsequence

  AST_START_BUSY: assert property (req |=> busy_ff && state_ff == ST_CONV)
    else $error("start not taken into conversion");
  AST_MSB_FIRST: assert property (req |=> dac_trial == `SCS_CODE_MID)
    else $error("first trial is not the MSB");
  AST_CONV_LEN: assert property (disable iff (!rstn || adc_reset)
    req |=> s_conv_run ##1 s_conv_end)
    else $error("conversion length wrong");
  AST_NO_LATENCY: assert property (done_w |-> $past(req, 16))
    else $error("result not from own start");
  AST_MODE_DEC: assert property (speed_sel && !accuracy_sel |->
    mode == MD_FAST) else $error("mode decode wrong");
  AST_FAST_RATE: assert property (req && fast_mode |->
    gap_ff >= FAST_PER) else $error("fast start too early");
  AST_FREE_RATE: assert property (req && !fast_mode |->
    gap_ff >= FREE_PER) else $error("free start too early");
  AST_MIDSCALE: assert property (done_w && !over_range && !under_range
    && !output_coding_sel |=> result_ff[15] != $past(kept[15]))
    else $error("twos complement MSB not inverted");
  AST_OVER_SAT: assert property (done_w && over_range && output_coding_sel
    |=> result_ff == `SCS_CODE_TOP) else $error("no top saturation");
  AST_UNDER_SAT: assert property (done_w && under_range && !over_range
    && !output_coding_sel |=> result_ff == `SCS_CODE_MID)
    else $error("no bottom saturation");
  AST_ABORT: assert property (adc_reset |=> !busy_ff && $stable(result_ff))
    else $error("reset did not abort");
  AST_CAL_PULSE: assert property ($fell(adc_reset) |=>
    busy_ff && state_ff == ST_CAL) else $error("no calibration pulse");
  AST_PD_BLOCK: assert property (power_down_in |-> !req)
    else $error("start taken in power-down");

  // Switches, busy level, binary coding and calibration length
  AST_SW_OPEN: assert property (state_ff == ST_CONV |->
    !pos_array_ground_switch && !neg_array_ground_switch)
    else $error("array switches closed during conversion");
  AST_BUSY_HOLD: assert property (state_ff == ST_CONV && !mask_ff[0]
    && !adc_reset |=> busy_ff) else $error("busy dropped early");
  AST_BIN_CODE: assert property (done_w && !over_range && !under_range
    && output_coding_sel |=> result_ff == $past(kept))
    else $error("straight binary code altered");
  AST_CAL_LEN: assert property (disable iff (!rstn || adc_reset)
    $fell(adc_reset) |=> s_conv_run ##1 !busy_ff)
    else $error("calibration length wrong");
  AST_CAL_BUSY: assert property (state_ff == ST_CAL |-> busy_ff)
    else $error("busy low during calibration");

endmodule

// File: tb/scs_host_model.sv
// Host model: issues conversion starts and collects results
module scs_host_model #(
  parameter int LOW_CYC = 2
) (
  // Clock
  input  wire logic        ref_clk,
  // Start requests
  input  wire logic        go,
  output logic             convert_start_n,
  // Results from the device
  input  wire logic        busy,
  input  wire logic [15:0] result_code,
  input  wire logic        stale_result,
  output logic [15:0]      last_code,
  output logic             keep
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt        = 0;
  logic        busy_q     = 1'b0;
  logic        start_n_ff = 1'b1;
  logic [15:0] code_ff    = 16'h0000;
  logic        keep_ff    = 1'b0;

  // Each output has a single driver
  assign convert_start_n = start_n_ff;
  assign last_code       = code_ff;
  assign keep            = keep_ff;

  // Start pin held low for a few cycles after each request
  always @(posedge ref_clk) begin
    if (go) begin
      start_n_ff <= 1'b0;
      cnt <= LOW_CYC;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      start_n_ff <= 1'b1;
    end
  end

  // Take the code when busy drops; stale codes are not kept
  always @(posedge ref_clk) begin
    busy_q <= busy;
    if (busy_q && !busy) begin
      code_ff <= result_code;
      keep_ff <= !stale_result;
    end
  end
endmodule

// File: tb/scs_sar_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer
module scs_sar_conversion_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, adc_reset = 1'b0, power_down_in = 1'b0;
  logic        speed_sel = 1'b1, accuracy_sel = 1'b1, go = 1'b0;
  logic        output_coding_sel = 1'b1, over_range = 1'b0;
  logic        under_range = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [15:0] ain = 16'h0000, held = 16'h0000, result_code, dac_trial;
  logic [15:0] last_code, keep_res;
  logic        pready, pslverr, busy, stale_result, keep, er;
  logic        convert_start_n, pos_sw, neg_sw, comp_in;
  logic [15:0] codes [4] = '{16'h8000, 16'h0000, 16'h7fff, 16'hfffe};
  logic [2:0]  modes [4] = '{3'b001, 3'b010, 3'b100, 3'b010};
  int          err_count = 0, check_count = 0, cyc = 0, n;

  scs_sar_conversion_sequencer #(.STALE_CYC(200)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convert_start_n(convert_start_n),
    .adc_reset(adc_reset), .power_down_in(power_down_in),
    .speed_sel(speed_sel), .accuracy_sel(accuracy_sel),
    .output_coding_sel(output_coding_sel), .busy(busy),
    .result_code(result_code), .stale_result(stale_result),
    .comp_in(comp_in), .over_range(over_range), .under_range(under_range),
    .dac_trial(dac_trial), .pos_array_ground_switch(pos_sw),
    .neg_array_ground_switch(neg_sw));

  scs_host_model u_host (
    .ref_clk(ref_clk), .go(go), .convert_start_n(convert_start_n),
    .busy(busy), .result_code(result_code), .stale_result(stale_result),
    .last_code(last_code), .keep(keep));

  // Clock and hang guard
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // Sample held while tracking; comparator against the trial word
  always @(posedge ref_clk) if (!busy) held <= ain;
  assign comp_in = (held >= dac_trial);

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic kick();
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask

  task automatic wait_hi();
    n = 0;
    while (busy !== 1'b1 && n < 20) begin @(posedge ref_clk); n++; end
  endtask

  task automatic count_hi();
    n = 0;
    while (busy === 1'b1 && n < 40) begin @(posedge ref_clk); n++; end
  endtask

  // Full conversion; input moves once held to expose any pipelining
  task automatic conv(input logic [15:0] v, input logic [15:0] exp);
    ain <= v;
    kick();
    wait_hi();
    check(dac_trial, 16'h8000);
    check(pos_sw, 1'b0);
    ain <= ~v;
    count_hi();
    check(n, 16);
    check(result_code, exp);
    repeat (70) @(posedge ref_clk);
    check(last_code, exp);
  endtask

  task automatic refused();
    kick();
    repeat (6) @(posedge ref_clk);
    check(busy, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check(busy, 1'b0);
    check(pos_sw, 1'b1);
    apb(1'b0, 12'h000, 32'h0000_0000, rd, er);
    check(rd, 32'h0000_0001);
    apb(1'b0, 12'h00c, 32'h0000_0000, rd, er);
    check(rd, 32'h0000_0000);
    check(er, 1'b1);
    apb(1'b0, 12'h004, 32'h0000_0000, rd, er);
    check(rd, 32'h0000_0018);
    conv(16'h1234, 16'h1234);
    check(stale_result, 1'b1);
    check(keep, 1'b0);
    apb(1'b0, 12'h008, 32'h0000_0000, rd, er);
    check(rd, 32'h0000_1234);
    conv(16'h0f0f, 16'h0f0f);
    check(stale_result, 1'b0);
    check(keep, 1'b1);
    for (int i = 0; i < 4; i++) begin
      speed_sel <= (i != 2);
      accuracy_sel <= (i == 0);
      output_coding_sel <= i[0];
      apb(1'b0, 12'h004, 32'h0000_0000, rd, er);
      check(rd[6:4], modes[i]);
      conv(codes[i], i[0] ? codes[i] : codes[i] ^ 16'h8000);
    end
    for (int i = 0; i < 2; i++) begin
      output_coding_sel <= i[0];
      over_range <= 1'b1;
      conv(16'h4321, i[0] ? 16'hffff : 16'h7fff);
      over_range <= 1'b0;
      under_range <= 1'b1;
      conv(16'h4321, i[0] ? 16'h0000 : 16'h8000);
      under_range <= 1'b0;
    end
    kick();
    repeat (48) @(posedge ref_clk);
    kick();
    repeat (2) @(posedge ref_clk);
    check(busy, 1'b1);
    power_down_in <= 1'b1;
    count_hi();
    check(n, 16);
    repeat (70) @(posedge ref_clk);
    refused();
    power_down_in <= 1'b0;
    speed_sel <= 1'b0;
    accuracy_sel <= 1'b0;
    kick();
    repeat (25) @(posedge ref_clk);
    refused();
    repeat (70) @(posedge ref_clk);
    apb(1'b1, 12'h000, 32'h0000_0003, rd, er);
    @(posedge ref_clk);
    check(busy, 1'b1);
    apb(1'b0, 12'h004, 32'h0000_0000, rd, er);
    check(rd, 32'h0000_0049);
    keep_res = result_code;
    repeat (3) @(posedge ref_clk);
    adc_reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check(busy, 1'b0);
    check(result_code, keep_res);
    adc_reset <= 1'b0;
    wait_hi();
    count_hi();
    check(n, 16);
    apb(1'b1, 12'h000, 32'h0000_0000, rd, er);
    refused();
    apb(1'b1, 12'h000, 32'h0000_0001, rd, er);
    tally_and_finish();
  end
endmodule
